/* bus_master.sv */
`timescale 1ns/10ps

// ==========
// Two-wire bus master: owns the clock, pulls the data line low
// ==========
module bus_master
(
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  logic lclk;

  // Tick clock, offset so it never lines up with a rising core clock edge
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end

  // Both lines released at rest; clock stands still between frames
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask

  // Works from idle or, as a repeated start, from clock low
  task automatic start_cond();
    sda_pull = 1'b0;
    tick(1);
    scl = 1'b1;
    tick(2);
    while (sda !== 1'b1) tick(1);
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask

  // Data set mid low phase; two samples span the second half of the high phase
  task automatic bit_xfer(input logic b, output logic s);
    logic s1;
    sda_pull = ~b;
    tick(1);
    scl = 1'b1;
    tick(1);
    s1 = sda;
    tick(1);
    s = s1 | sda;
    scl = 1'b0;
    tick(1);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], s);
    bit_xfer(1'b1, nak);
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, b[i]);
    bit_xfer(~ack, s);
  endtask

  task automatic stop_cond();
    sda_pull = 1'b1;
    tick(1);
    scl = 1'b1;
    tick(2);
    sda_pull = 1'b0;
    tick(2);
  endtask
endmodule

/* i2c_slave_bus_interface.sv */
`timescale 1ns/10ps

module i2c_slave_bus_interface
  import i2c_slave_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output      logic       sda_out,
  output      logic       sda_oe,
  input  wire logic       addr_strap_0,
  input  wire logic       addr_strap_1,
  input  wire logic       addr_strap_2,
  input  wire logic [7:0] tx_data,
  output      logic       tx_take,
  output      logic [7:0] rx_data,
  output      logic       rx_valid,
  output      logic       bus_busy,
  output      logic       selected,
  output      logic       read_mode,
  output      logic       start_pulse,
  output      logic       stop_pulse,
  output      logic       nack_pulse,
  output      logic [7:0] dev_addr
);

  // ==========================================================
  // Pin capture and bus clock domain
  // ==========================================================
  logic [PIN_W-1:0] pins_q;
  link_shift_if     link ();

  pin_sync u_sync (
    .clk    (clk),
    .rst    (rst),
    .pins   ({addr_strap_2, addr_strap_1, addr_strap_0, sda_in, scl}),
    .pins_q (pins_q)
  );

  link_shifter u_shift (
    .scl    (scl),
    .sda_in (sda_in),
    .link   (link.shifter)
  );

  // ==========================================================
  // Core state
  // ==========================================================
  typedef struct packed {
    bus_state_e         state;
    logic [3:0]         bitcnt;
    logic               scl_prev;
    logic               sda_prev;
    logic [7:0]         txsh;
    logic               mack;
    logic [STRAPS-1:0]  saw_low;
    logic [STRAPS-1:0]  diff_sda;
    logic [STRAPS-1:0]  diff_scl;
    logic               sda_out;
    logic               sda_oe;
    logic               tx_take;
    logic [7:0]         rx_data;
    logic               rx_valid;
    logic               bus_busy;
    logic               selected;
    logic               read_mode;
    logic               start_pulse;
    logic               stop_pulse;
    logic               nack_pulse;
    logic [7:0]         dev_addr;
  } core_s;

  core_s st;
  core_s next_st;

  logic scl_f;
  logic sda_f;
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;
  logic addr_hit;

  // Edge and condition detect on the filtered lines
  assign scl_f    = pins_q[PIN_SCL];
  assign sda_f    = pins_q[PIN_SDA];
  assign rise_ev  = scl_f & ~st.scl_prev;
  assign fall_ev  = ~scl_f & st.scl_prev;
  assign start_ev = scl_f & st.scl_prev & st.sda_prev & ~sda_f;
  assign stop_ev  = scl_f & st.scl_prev & ~st.sda_prev & sda_f;
  assign addr_hit = (link.rx_shift[7:1] == st.dev_addr[7:1]);

  // ==========================================================
  // Strap classification
  // ==========================================================
  logic [STRAPS-1:0] strap_bus;
  logic [STRAPS-1:0] strap_lsb;
  logic [7:0]        addr_w;

  // A strap that never differs from a bus line but went low is tied
  // to it; classes settle once START and the first clock have passed
  genvar gi;
  generate
    for (gi = 0; gi < STRAPS; gi++)
    begin : g_strap
      logic is_sda;
      logic is_scl;
      assign is_sda = ~st.diff_sda[gi] & st.saw_low[gi];
      assign is_scl = ~is_sda & ~st.diff_scl[gi] & st.saw_low[gi];
      assign strap_bus[gi] = is_sda | is_scl;
      assign strap_lsb[gi] = is_sda | (~strap_bus[gi] & ~st.saw_low[gi]);
    end
  endgenerate

  assign addr_w = {ADDR_TOP, strap_bus[2], strap_bus[0], strap_bus[1],
                   strap_lsb[2], strap_lsb[1], strap_lsb[0], 1'b0};

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    logic [STRAPS-1:0] sp;
    sp                  = pins_q[PIN_STRAP +: STRAPS];
    next_st             = st;
    next_st.scl_prev    = scl_f;
    next_st.sda_prev    = sda_f;
    next_st.sda_out     = 1'b0;  // Open drain: only ever pulls low
    next_st.tx_take     = 1'b0;
    next_st.rx_valid    = 1'b0;
    next_st.start_pulse = 1'b0;
    next_st.stop_pulse  = 1'b0;
    next_st.nack_pulse  = 1'b0;
    // Strap sensing runs from reset release onward
    next_st.saw_low     = st.saw_low | ~sp;
    next_st.diff_sda    = st.diff_sda | (sp ^ {STRAPS{sda_f}});
    next_st.diff_scl    = st.diff_scl | (sp ^ {STRAPS{scl_f}});
    next_st.dev_addr    = addr_w;
    if (rise_ev)
    begin
      next_st.bitcnt = st.bitcnt + 4'h1;
    end

    if (stop_ev)
    begin
      next_st.state      = ST_IDLE;
      next_st.sda_oe     = 1'b0;
      next_st.bus_busy   = 1'b0;
      next_st.selected   = 1'b0;
      next_st.stop_pulse = 1'b1;
    end
    else if (start_ev)
    begin
      // Repeated START also lands here: framing restarts mid-byte
      next_st.state       = ST_ADDR;
      next_st.bitcnt      = CNT_RST;
      next_st.sda_oe      = 1'b0;
      next_st.bus_busy    = 1'b1;
      next_st.selected    = 1'b0;
      next_st.start_pulse = 1'b1;
    end
    else
    begin
      case (st.state)
        ST_IDLE:
        begin
          next_st.sda_oe = 1'b0;
        end
        ST_ADDR:
        begin
          if (fall_ev && st.bitcnt == BYTE_BITS)
          begin
            if (addr_hit)
            begin
              next_st.selected  = 1'b1;
              next_st.read_mode = link.rx_shift[0];
              next_st.sda_oe    = 1'b1;
              next_st.state     = ST_SACK;
            end
            else
            begin
              next_st.state = ST_IGNORE;
            end
          end
        end
        ST_SACK:
        begin
          // Held low until the ninth clock falls again
          if (fall_ev && st.bitcnt == ACK_BITS)
          begin
            next_st.bitcnt = CNT_RST;
            if (st.read_mode)
            begin
              next_st.txsh    = tx_data;
              next_st.tx_take = 1'b1;
              next_st.sda_oe  = ~tx_data[7];
              next_st.state   = ST_TX;
            end
            else
            begin
              next_st.sda_oe = 1'b0;
              next_st.state  = ST_RX;
            end
          end
        end
        ST_RX:
        begin
          if (fall_ev && st.bitcnt == BYTE_BITS)
          begin
            next_st.rx_data  = link.rx_shift;
            next_st.rx_valid = 1'b1;
            next_st.sda_oe   = 1'b1;
            next_st.state    = ST_SACK;
          end
        end
        ST_TX:
        begin
          if (fall_ev)
          begin
            if (st.bitcnt == BYTE_BITS)
            begin
              next_st.sda_oe = 1'b0;
              next_st.state  = ST_MACK;
            end
            else
            begin
              next_st.txsh   = {st.txsh[6:0], 1'b0};
              next_st.sda_oe = ~st.txsh[6];
            end
          end
        end
        ST_MACK:
        begin
          if (rise_ev)
          begin
            next_st.mack = ~sda_f;
          end
          if (fall_ev && st.bitcnt == ACK_BITS)
          begin
            next_st.bitcnt = CNT_RST;
            if (st.mack)
            begin
              next_st.txsh    = tx_data;
              next_st.tx_take = 1'b1;
              next_st.sda_oe  = ~tx_data[7];
              next_st.state   = ST_TX;
            end
            else
            begin
              next_st.nack_pulse = 1'b1;
              next_st.sda_oe     = 1'b0;
              next_st.state      = ST_IGNORE;
            end
          end
        end
        ST_IGNORE:
        begin
          next_st.sda_oe = 1'b0;
        end
        default:
        begin
          next_st.state  = ST_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Single register stage for the whole core
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '{ST_IDLE, CNT_RST, 1'b1, 1'b1, BYTE_RST, 1'b0,
              '0, '0, '0, 1'b0, 1'b0, 1'b0, BYTE_RST, 1'b0,
              1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ADDR_RST};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, all from the core register
  // ==========================================================
  assign sda_out     = st.sda_out;
  assign sda_oe      = st.sda_oe;
  assign tx_take     = st.tx_take;
  assign rx_data     = st.rx_data;
  assign rx_valid    = st.rx_valid;
  assign bus_busy    = st.bus_busy;
  assign selected    = st.selected;
  assign read_mode   = st.read_mode;
  assign start_pulse = st.start_pulse;
  assign stop_pulse  = st.stop_pulse;
  assign nack_pulse  = st.nack_pulse;
  assign dev_addr    = st.dev_addr;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rx_byte_end;
    st.state == ST_RX && fall_ev && st.bitcnt == BYTE_BITS;
  endsequence

  sequence tx_byte_end;
    st.state == ST_TX && fall_ev && st.bitcnt == BYTE_BITS;
  endsequence

  sequence addr_miss;
    st.state == ST_ADDR && fall_ev && st.bitcnt == BYTE_BITS && !addr_hit
      && !start_ev && !stop_ev;
  endsequence

  chk_idle_released: assert property (
    st.state == ST_IDLE |-> !sda_oe && !bus_busy)
    else $error("data line driven while idle");

  chk_start_restart: assert property (
    start_ev && !stop_ev |=> st.state == ST_ADDR && st.bitcnt == CNT_RST
      && start_pulse && !sda_oe)
    else $error("start did not restart framing");

  chk_stop_idle: assert property (
    stop_ev |=> st.state == ST_IDLE && stop_pulse ##1 !bus_busy)
    else $error("stop did not return to idle");

  chk_bit_count: assert property (
    rise_ev && !start_ev && !stop_ev |=> st.bitcnt == $past(st.bitcnt) + 4'h1)
    else $error("bit count not stepped by clock pulse");

  chk_rx_ack: assert property (
    rx_byte_end and !start_ev && !stop_ev |=> rx_valid && sda_oe
      && st.state == ST_SACK)
    else $error("received byte not acknowledged");

  chk_ack_held: assert property (
    st.state == ST_SACK && sda_oe && !fall_ev && !start_ev && !stop_ev
      |=> sda_oe)
    else $error("acknowledge dropped early");

  chk_tx_release: assert property (
    tx_byte_end and !start_ev && !stop_ev |=> !sda_oe && st.state == ST_MACK)
    else $error("transmitter held line in ack slot");

  chk_nack_quiet: assert property (
    nack_pulse |-> !sda_oe ##1 !sda_oe)
    else $error("line driven after master nack");

  chk_addr_miss: assert property (
    addr_miss |=> st.state == ST_IGNORE && !sda_oe && !selected)
    else $error("unmatched address not ignored");

  chk_drive_low_clk: assert property (
    $rose(sda_oe) |-> !$past(scl_f))
    else $error("drive started while clock high");

  chk_rx_continue: assert property (
    st.state == ST_SACK && !st.read_mode && fall_ev && st.bitcnt == ACK_BITS
      && !start_ev && !stop_ev |=> st.state == ST_RX && st.bitcnt == CNT_RST)
    else $error("receive did not continue after ack");

endmodule

/* i2c_slave_bus_interface_tb.sv */
`timescale 1ns/10ps

// ==========
// Bench for the two-wire slave front end
// ==========
module i2c_slave_bus_interface_tb;
  // Strap select: 0 low, 1 high, 2 clock line, 3 data line
  typedef struct {
    logic [1:0] s2, s1, s0;
    logic [7:0] addr, data;
  } row_s;

  logic       clk, rst, scl, sda, sda_pull, sda_out, sda_oe, nak;
  logic       addr_strap_0, addr_strap_1, addr_strap_2;
  logic       tx_take, rx_valid, bus_busy, selected, read_mode;
  logic       start_pulse, stop_pulse, nack_pulse;
  logic [7:0] tx_data, rx_data, dev_addr, got;
  logic [1:0] sel [3];
  int         miscompares, samples_checked, rx_n, tx_n, nk_n, st_n;
  int         r0, t0, n0, s0, p0, sp_n;
  logic [7:0] tx_tab [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
  row_s       rows [6] = '{'{2'h3, 2'h0, 2'h2, 8'hE8, 8'h5A},
                           '{2'h3, 2'h0, 2'h3, 8'hEA, 8'h81},
                           '{2'h3, 2'h1, 2'h2, 8'hEC, 8'hFF},
                           '{2'h3, 2'h0, 2'h0, 8'hC8, 8'h00},
                           '{2'h2, 2'h1, 2'h2, 8'hE4, 8'h96},
                           '{2'h0, 2'h1, 2'h0, 8'h84, 8'h3C}};

  // Open-drain data line with pull-up; straps follow their ties
  assign sda = ~(sda_pull | (sda_oe & ~sda_out));
  assign addr_strap_0 = sel[0][1] ? (sel[0][0] ? sda : scl) : sel[0][0];
  assign addr_strap_1 = sel[1][1] ? (sel[1][0] ? sda : scl) : sel[1][0];
  assign addr_strap_2 = sel[2][1] ? (sel[2][0] ? sda : scl) : sel[2][0];

  i2c_slave_bus_interface i2c_slave_bus_interface_i (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_0(addr_strap_0),
    .addr_strap_1(addr_strap_1), .addr_strap_2(addr_strap_2),
    .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data),
    .rx_valid(rx_valid), .bus_busy(bus_busy), .selected(selected),
    .read_mode(read_mode), .start_pulse(start_pulse),
    .stop_pulse(stop_pulse), .nack_pulse(nack_pulse), .dev_addr(dev_addr)
  );

  bus_master bus_master_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // Core clock, 5 ns period
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Pulse tallies; pulses last one cycle so every edge is counted
  always @(posedge clk)
  begin
    if (rx_valid) rx_n++;
    if (tx_take) tx_n++;
    if (nack_pulse) nk_n++;
    if (start_pulse) st_n++;
    if (stop_pulse) sp_n++;
  end

  // Next byte to send is offered as soon as the last one was taken
  always @(negedge clk) tx_data <= tx_tab[tx_n % 4];

  // Slave may move its drive only while the clock is low
  always @(sda_oe)
    if (rst === 1'b0) chk(scl, 8'h00, "drive moved, clock high");

  task automatic chk(input logic [7:0] g, e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, m, g, e);
    end
  endtask

  // Straps are classified after reset, so each row starts afresh
  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Cut a hang short; the tests need well under 100 us
  initial
  begin
    #200000;
    miscompares++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    summarize();
  end

  // ==========
  // Main sequence
  // ==========
  initial
  begin
    rst = 1'b1;
    tx_data = 8'hA5;
    sel = '{2'h1, 2'h1, 2'h1};
    @(negedge clk);
    do_reset();
    chk({4'h0, sda_oe, bus_busy, selected, read_mode}, 8'h00, "reset");
    chk(rx_data, 8'h00, "reset byte");
    foreach (rows[k])
    begin
      @(negedge clk);
      sel = '{rows[k].s0, rows[k].s1, rows[k].s2};
      do_reset();
      r0 = rx_n;
      p0 = sp_n;
      bus_master_i.start_cond();
      bus_master_i.send_byte(rows[k].addr, nak);
      chk(nak, 8'h00, "address ack");
      chk({selected, read_mode}, 8'h02, "write select");
      bus_master_i.send_byte(rows[k].data, nak);
      chk(nak, 8'h00, "data ack");
      chk(rx_data, rows[k].data, "first byte");
      bus_master_i.send_byte(~rows[k].data, nak);
      chk(nak, 8'h00, "second ack");
      chk(rx_data, ~rows[k].data, "second byte");
      bus_master_i.stop_cond();
      chk(8'(rx_n - r0), 8'h02, "byte count");
      chk(dev_addr, rows[k].addr, "strap address");
      chk(bus_busy, 8'h00, "busy after stop");
      chk(8'(sp_n - p0), 8'h01, "stop seen");
      $display("test strap row %0d done", k);
    end
    r0 = rx_n;
    bus_master_i.start_cond();
    bus_master_i.send_byte(8'h86, nak);
    chk(nak, 8'h01, "foreign address");
    bus_master_i.send_byte(8'h55, nak);
    chk(nak, 8'h01, "ignored byte");
    chk({7'h00, selected}, 8'h00, "not selected");
    chk(8'(rx_n - r0), 8'h00, "nothing taken");
    bus_master_i.stop_cond();
    $display("test foreign address done");
    t0 = tx_n;
    n0 = nk_n;
    bus_master_i.start_cond();
    bus_master_i.send_byte(8'h85, nak);
    chk({nak, read_mode}, 8'h01, "read select");
    bus_master_i.recv_byte(1'b1, got);
    chk(got, tx_tab[t0 % 4], "first read byte");
    bus_master_i.recv_byte(1'b0, got);
    chk(got, tx_tab[(t0 + 1) % 4], "last read byte");
    chk(8'(nk_n - n0), 8'h01, "nack seen");
    chk(sda_oe, 8'h00, "released after nack");
    bus_master_i.stop_cond();
    chk(8'(tx_n - t0), 8'h02, "bytes fetched");
    $display("test read done");
    r0 = rx_n;
    s0 = st_n;
    bus_master_i.start_cond();
    bus_master_i.send_byte(8'h84, nak);
    for (int i = 0; i < 3; i++)
      bus_master_i.bit_xfer(1'b0, nak);
    bus_master_i.start_cond();
    chk(bus_busy, 8'h01, "busy after restart");
    bus_master_i.send_byte(8'h84, nak);
    bus_master_i.send_byte(8'hC3, nak);
    chk(nak, 8'h00, "ack after restart");
    bus_master_i.stop_cond();
    chk(rx_data, 8'hC3, "byte after restart");
    chk(8'(rx_n - r0), 8'h01, "partial dropped");
    chk(8'(st_n - s0), 8'h02, "starts seen");
    $display("test repeated start done");
    summarize();
  end
endmodule

/* i2c_slave_pkg.sv */
package i2c_slave_pkg;

  // ==========================================================
  // Framing constants
  // ==========================================================
  localparam logic [3:0] BYTE_BITS = 4'h8;  // Data bits per byte
  localparam logic [3:0] ACK_BITS  = 4'h9;  // Byte plus acknowledge slot
  localparam logic [3:0] CNT_RST   = 4'h0;

  // ==========================================================
  // Pin vector layout after the synchroniser
  // ==========================================================
  localparam int         PIN_W     = 5;
  localparam int         PIN_SCL   = 0;
  localparam int         PIN_SDA   = 1;
  localparam int         PIN_STRAP = 2;     // Straps 0..2 at 2..4
  localparam int         STRAPS    = 3;
  localparam logic [4:0] PIN_RST   = 5'h1F; // Idle bus reads high

  // ==========================================================
  // Address built from the strap classes
  // ==========================================================
  localparam logic       ADDR_TOP  = 1'b1;  // Bit 7 of the address
  localparam logic [7:0] ADDR_RST  = 8'h00;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // ==========================================================
  // Bus state machine
  // ==========================================================
  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_ADDR   = 7'b0000010,
    ST_SACK   = 7'b0000100,
    ST_RX     = 7'b0001000,
    ST_TX     = 7'b0010000,
    ST_MACK   = 7'b0100000,
    ST_IGNORE = 7'b1000000
  } bus_state_e;

endpackage

/* link_shift_if.sv */
`timescale 1ns/10ps

// ============================================================
// Serial byte carried from the bus clock domain to the core
// ============================================================
interface link_shift_if;
  logic [7:0] rx_shift;

  modport shifter (output rx_shift);
  modport core    (input  rx_shift);
endinterface

/* link_shifter.sv */
`timescale 1ns/10ps

// ============================================================
// Bus clock domain: one data bit per clock pulse
// ============================================================
module link_shifter
  import i2c_slave_pkg::*;
(
  input  wire logic      scl,
  input  wire logic      sda_in,
  link_shift_if.shifter  link
);

  typedef struct packed {
    logic [7:0] sh;
  } shift_s;

  shift_s st;
  shift_s next_st;

  // MSB first; the core reads it while the clock is low
  always_comb
  begin
    next_st    = st;
    next_st.sh = {st.sh[6:0], sda_in};
  end

  // No reset: clock stands still outside frames, core does framing
  always_ff @(posedge scl)
  begin
    st <= next_st;
  end

  assign link.rx_shift = st.sh;

endmodule

/* pin_sync.sv */
`timescale 1ns/10ps

// ============================================================
// Three-stage pin synchroniser with agreement filter
// ============================================================
module pin_sync
  import i2c_slave_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic [i2c_slave_pkg::PIN_W-1:0] pins,
  output      logic [i2c_slave_pkg::PIN_W-1:0] pins_q
);

  typedef struct packed {
    logic [PIN_W-1:0] ff1;
    logic [PIN_W-1:0] ff2;
    logic [PIN_W-1:0] ff3;
    logic [PIN_W-1:0] q;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // Output moves only where the second and third stage agree
  always_comb
  begin
    next_st     = st;
    next_st.ff1 = pins;
    next_st.ff2 = st.ff1;    // First stage feeds nothing else
    next_st.ff3 = st.ff2;
    next_st.q   = (st.ff2 & st.ff3) | (st.q & (st.ff2 ^ st.ff3));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '{PIN_RST, PIN_RST, PIN_RST, PIN_RST};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pins_q = st.q;

endmodule
